// *** pkg/bmm_defines.vh ***
`ifndef BMM_DEFINES_VH
`define BMM_DEFINES_VH

// ----------------------------------------
// Operating modes {mode_bit_high, mode_bit_low}
// ----------------------------------------
`define BMM_MODE_BOOT_BYTE 2'b00
`define BMM_MODE_BOOT_PORT 2'b01
`define BMM_MODE_EXPANDED 2'b10
`define BMM_MODE_DEVELOP 2'b11

// ----------------------------------------
// Program space addresses
// ----------------------------------------
`define BMM_BOOT_BASE 16'hc000
`define BMM_ZERO_ADDR 16'h0000
`define BMM_EXP_RESET_VEC 16'he000
`define BMM_VECTOR_TOP 16'h003f
`define BMM_SRC_BIT 15
`define BMM_INTERNAL_PROGRAM_RAM_WORDS 2048
`define BMM_PROM_WORDS 12288

// ----------------------------------------
// Data space map
// ----------------------------------------
`define BMM_DRAM_WORDS 2048
`define BMM_DRAM_TOP 16'h07ff
`define BMM_PERIPH_BASE 16'hffc0
`define BMM_REGION_INT 2'b00
`define BMM_REGION_EXT 2'b01
`define BMM_REGION_PERIPH 2'b10

// ----------------------------------------
// Load sources
// ----------------------------------------
`define BMM_SRC_BYTE 2'b00
`define BMM_SRC_HOST 2'b01
`define BMM_SRC_SERIAL 2'b10

// ----------------------------------------
// Register bus
// ----------------------------------------
`define BMM_REG_MODE 8'h00
`define BMM_REG_STATUS 8'h04
`define BMM_REG_COUNT 8'h08
`define BMM_RESP_OKAY 2'b00
`define BMM_RESP_SLVERR 2'b10

`endif

// *** rtl/bmm_data_ram.v ***
`timescale 1ns/1ps
`include "bmm_defines.vh"

module bmm_data_ram
#(
  parameter WORDS = `BMM_DRAM_WORDS,
  parameter AW = 11
)
(
  input wire core_clk,
  input wire wrEn,
  input wire [AW-1:0] wrAddr,
  input wire [15:0] wrData,
  input wire [1:0] rdEn,
  input wire [2*AW-1:0] rdAddr,
  output wire [31:0] rdData
);

  reg [15:0] mem [0:WORDS-1];

  always @(posedge core_clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  // ----------------------------------------
  // Read ports; a write cycle takes the array, so reads in that cycle are skipped and keep old data
  // ----------------------------------------
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : gRead
      reg [15:0] q;
      always @(posedge core_clk)
      begin
        if (rdEn[p] && !wrEn) // [RULE9]
        begin
          q <= mem[rdAddr[AW*p+AW-1:AW*p]];
        end
      end
      assign rdData[16*p+15:16*p] = q;
    end
  endgenerate

endmodule // bmm_data_ram

// *** rtl/bmm_boot_loader.v ***
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "bmm_defines.vh"

// What this block does
// [RULE1] Mode 0 loads program RAM from external byte memory at C000.
// [RULE2] Even byte gives low byte, odd byte high byte; C000..CFFF fill 0..7FF.
// [RULE3] Mode 1 reads bit 15 at C000: zero picks host, one picks serial.
// [RULE4] Host writes transmit high and low bytes with words for 0..7FF.
// [RULE5] Host flag zero set ends a host load early.
// [RULE6] Serial load sets serial port zero to 8 bits, external clock, async.
// [RULE7] Data RAM is 16 bits wide at data addresses 0..7FF.
// [RULE8] Data addresses FFC0..FFFF go to peripheral registers.
// [RULE9] Data RAM does two reads, one read or one write per cycle.
// [RULE10] Program and data spaces each have 65536 addresses, external beyond internal.
// [RULE11] Read-only variant has a 12288-word program ROM enabled by mode bits.
// [RULE12] Program addresses 0..3F are interrupt vectors.
// [RULE13] Mode pins sampled at reset release, then first two are interrupt requests.
// [RULE14] Writing the mode bits changes the map at once, no reset.
// [RULE15] Software masks interrupts and adds one no-op around mode changes.
// [RULE16] Mode 0 enables internal program memory, reset vector at internal 0000.
// [RULE17] Mode 2 has mode 0 map but reset vector at external E000.
// [RULE18] Mode 3 disables internal program memory, all external, vector 0000.
// [RULE19] Read-only variant treats mode 1 as mode 0.
// [RULE20] Board strap: low pin low, high pin high picks mode 2.
// [RULE21] Loading modes decode 00 as byte memory, 01 as host or serial.
// [RULE22] While loading, loader ROM sits at 0000 and serves every fetch.
// [RULE23] While loading, program RAM is write-only and takes every write; a core write in a cycle that stores a loader word is dropped.
// [RULE24] Load ends by entering mode 2 and branching to 0000.
// [RULE25] Current mode is a two-bit register from pins, then mode-bit writes.

module bmm_boot_loader
#(
  parameter ROM_VARIANT = 0,
  parameter INTERNAL_PROGRAM_RAM_WORDS = `BMM_INTERNAL_PROGRAM_RAM_WORDS,
  parameter PROM_WORDS = `BMM_PROM_WORDS
)
(
  input wire core_clk,
  input wire rst_b,
  input wire modePinLow,
  input wire modePinHigh,
  input wire modePinThird,
  output wire interruptRequestA,
  output wire interruptRequestB,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [15:0] extAddr,
  output reg extReadEn,
  input wire [15:0] extDataIn,
  input wire extAck,
  input wire [15:0] hostWord,
  input wire hostWordValid,
  output wire hostWordReady,
  input wire hostFlagZero,
  input wire [7:0] serialByte,
  input wire serialByteValid,
  output wire serialByteReady,
  output reg serialWordLen8,
  output reg serialExtClock,
  output reg serialAsync,
  input wire [15:0] progAddr,
  input wire progFetch,
  input wire progWriteEn,
  input wire [15:0] progWriteData,
  output reg [15:0] progReadData,
  output wire progSelBootRom,
  output wire progSelInternal,
  output wire progSelExternal,
  output wire progVectorArea,
  output reg [15:0] resetVector,
  output reg branchToZero,
  input wire [15:0] dataAddrOne,
  input wire [15:0] dataAddrTwo,
  input wire dataReadOne,
  input wire dataReadTwo,
  input wire dataWrite,
  input wire [15:0] dataWriteData,
  output wire [1:0] dataRegionOne,
  output wire [1:0] dataRegionTwo,
  output wire [15:0] dataOutOne,
  output wire [15:0] dataOutTwo
);

  localparam S_IDLE = 3'd0;
  localparam S_SELECT = 3'd1;
  localparam S_BYTE_LO = 3'd2;
  localparam S_BYTE_HI = 3'd3;
  localparam S_HOST = 3'd4;
  localparam S_SER_LO = 3'd5;
  localparam S_SER_HI = 3'd6;

  // ----------------------------------------
  // Address decoding
  // ----------------------------------------
  function [1:0] dataRegion;
    input [15:0] a;
    begin
      if (a <= `BMM_DRAM_TOP)
        dataRegion = `BMM_REGION_INT; // [RULE7]
      else if (a >= `BMM_PERIPH_BASE)
        dataRegion = `BMM_REGION_PERIPH; // [RULE8]
      else
        dataRegion = `BMM_REGION_EXT; // [RULE10]
    end
  endfunction

  function progInternal;
    input [1:0] m;
    input [15:0] a;
    begin
      if (m == `BMM_MODE_DEVELOP)
        progInternal = 1'b0; // [RULE18]
      else if (ROM_VARIANT != 0)
        progInternal = ({16'h0000, a} < PROM_WORDS); // [RULE11]
      else
        progInternal = ({16'h0000, a} < INTERNAL_PROGRAM_RAM_WORDS); // [RULE16]
    end
  endfunction

  reg [1:0] mode;
  reg modeThird;
  reg started;
  reg loading;
  reg loadDone;
  reg [1:0] loadSrc;
  reg [2:0] state;
  reg [10:0] wordIdx;
  reg [11:0] wordCount;
  reg [7:0] lowByte;
  reg [15:0] internal_program_ram [0:INTERNAL_PROGRAM_RAM_WORDS-1];

  reg awTaken;
  reg wTaken;
  reg [7:0] awAddrHeld;
  reg [31:0] wDataHeld;
  reg [3:0] wStrbHeld;

  // ----------------------------------------
  // Mode pins and interrupt requests
  // ----------------------------------------
  // Pins only become request inputs once the strap has been caught
  assign interruptRequestA = started & modePinLow; // [RULE13]
  assign interruptRequestB = started & modePinHigh; // [RULE13]

  wire strapBoot = !started && rst_b && (ROM_VARIANT == 0) && !modePinHigh; // [RULE20]
  wire commit = awTaken && wTaken && !s_axi_bvalid;
  wire modeWrite = commit && (awAddrHeld == `BMM_REG_MODE) && wStrbHeld[0];
  wire swBoot = modeWrite && (ROM_VARIANT == 0) && !wDataHeld[1];
  wire startLoad = strapBoot || swBoot;

  wire hostTake = (state == S_HOST) && hostWordValid && !hostFlagZero;
  wire serTake = ((state == S_SER_LO) || (state == S_SER_HI)) && serialByteValid;
  wire extTake = ((state == S_BYTE_LO) || (state == S_BYTE_HI)) && extReadEn && extAck;
  wire lastWord = (wordIdx == INTERNAL_PROGRAM_RAM_WORDS - 1);
  wire wordDone = (state == S_HOST && hostTake) ||
                  (state == S_BYTE_HI && extTake) ||
                  (state == S_SER_HI && serTake);
  wire [15:0] loadWord = (state == S_HOST) ? hostWord :
                         (state == S_BYTE_HI) ? {extDataIn[7:0], lowByte} :
                         {serialByte, lowByte};
  // Flag zero ends a host load; a word offered with it is dropped
  wire hostEnd = (state == S_HOST) && hostFlagZero; // [RULE5]
  wire finish = (wordDone && lastWord && !hostEnd) || hostEnd;

  assign hostWordReady = (state == S_HOST) && !hostFlagZero; // [RULE4]
  assign serialByteReady = (state == S_SER_LO) || (state == S_SER_HI);

  // ----------------------------------------
  // Mode register
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      mode <= `BMM_MODE_BOOT_BYTE;
      modeThird <= 1'b0;
      started <= 1'b0;
    end
    else if (!started)
    begin
      mode <= {modePinHigh, modePinLow}; // [RULE13] [RULE25]
      modeThird <= modePinThird;
      started <= 1'b1;
    end
    else if (modeWrite)
    begin
      mode <= wDataHeld[1:0]; // [RULE14] [RULE25]
    end
    else if (finish)
    begin
      mode <= `BMM_MODE_EXPANDED; // [RULE24]
    end
  end

  always @*
  begin
    case (mode)
      `BMM_MODE_EXPANDED: resetVector = `BMM_EXP_RESET_VEC; // [RULE17]
      default: resetVector = `BMM_ZERO_ADDR; // [RULE16] [RULE18] [RULE19]
    endcase
  end

  // ----------------------------------------
  // Loader sequence
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state <= S_IDLE;
      loading <= 1'b0;
      loadDone <= 1'b0;
      loadSrc <= `BMM_SRC_BYTE;
      wordIdx <= 11'h000;
      wordCount <= 12'h000;
      lowByte <= 8'h00;
      extAddr <= `BMM_BOOT_BASE;
      extReadEn <= 1'b0;
      branchToZero <= 1'b0;
      serialWordLen8 <= 1'b0;
      serialExtClock <= 1'b0;
      serialAsync <= 1'b0;
    end
    else
    begin
      branchToZero <= 1'b0;
      if (wordDone)
      begin
        wordIdx <= wordIdx + 11'h001;
        wordCount <= wordCount + 12'h001;
      end
      if (startLoad)
      begin
        loading <= 1'b1;
        loadDone <= 1'b0;
        wordIdx <= 11'h000;
        wordCount <= 12'h000;
        extAddr <= `BMM_BOOT_BASE;
        extReadEn <= 1'b1;
        // Strap case reads the pins directly, the mode register is still empty
        if ((strapBoot ? modePinLow : wDataHeld[0]) == 1'b0) // [RULE21]
        begin
          state <= S_BYTE_LO; // [RULE1]
          loadSrc <= `BMM_SRC_BYTE;
        end
        else
        begin
          state <= S_SELECT; // [RULE3]
        end
      end
      else if (finish)
      begin
        state <= S_IDLE;
        loading <= 1'b0;
        loadDone <= 1'b1;
        extReadEn <= 1'b0;
        branchToZero <= 1'b1; // [RULE24]
      end
      else
      begin
        case (state)
          S_SELECT:
          begin
            if (extAck)
            begin
              extReadEn <= 1'b0;
              if (extDataIn[`BMM_SRC_BIT]) // [RULE3]
              begin
                state <= S_SER_LO;
                loadSrc <= `BMM_SRC_SERIAL;
                serialWordLen8 <= 1'b1; // [RULE6]
                serialExtClock <= 1'b1; // [RULE6]
                serialAsync <= 1'b1; // [RULE6]
              end
              else
              begin
                state <= S_HOST;
                loadSrc <= `BMM_SRC_HOST;
              end
            end
          end
          S_BYTE_LO:
          begin
            if (extTake)
            begin
              lowByte <= extDataIn[7:0]; // [RULE2]
              extAddr <= extAddr + 16'h0001;
              state <= S_BYTE_HI;
            end
          end
          S_BYTE_HI:
          begin
            if (extTake)
            begin
              extAddr <= extAddr + 16'h0001; // [RULE2]
              state <= S_BYTE_LO;
            end
          end
          S_SER_LO:
          begin
            if (serTake)
            begin
              lowByte <= serialByte;
              state <= S_SER_HI;
            end
          end
          S_SER_HI:
          begin
            if (serTake)
            begin
              state <= S_SER_LO;
            end
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Program memory map
  // ----------------------------------------
  assign progSelBootRom = loading; // [RULE22]
  assign progSelInternal = !loading && progInternal(mode, progAddr);
  assign progSelExternal = !loading && !progInternal(mode, progAddr); // [RULE10]
  assign progVectorArea = (progAddr <= `BMM_VECTOR_TOP); // [RULE12]

  // Loader words win the write port; core writes during a load land in RAM too
  always @(posedge core_clk)
  begin
    if (wordDone && !hostEnd)
      internal_program_ram[wordIdx] <= loadWord; // [RULE2] [RULE23]
    else if (progWriteEn && (ROM_VARIANT == 0) && (loading || progInternal(mode, progAddr)))
      internal_program_ram[progAddr[10:0]] <= progWriteData; // [RULE23]
  end

  // Fetches during a load come from the loader ROM, so RAM reads back nothing
  always @(posedge core_clk)
  begin
    if (!rst_b)
      progReadData <= 16'h0000;
    else if (progFetch && progSelInternal && (ROM_VARIANT == 0))
      progReadData <= internal_program_ram[progAddr[10:0]];
    else
      progReadData <= 16'h0000; // [RULE23]
  end

  // ----------------------------------------
  // Data memory
  // ----------------------------------------
  assign dataRegionOne = dataRegion(dataAddrOne);
  assign dataRegionTwo = dataRegion(dataAddrTwo);

  bmm_data_ram #(.WORDS(`BMM_DRAM_WORDS), .AW(11)) uDataRam
  (
    .core_clk(core_clk),
    .wrEn(dataWrite && (dataRegionOne == `BMM_REGION_INT)),
    .wrAddr(dataAddrOne[10:0]),
    .wrData(dataWriteData),
    .rdEn({dataReadTwo && (dataRegionTwo == `BMM_REGION_INT),
           dataReadOne && (dataRegionOne == `BMM_REGION_INT)}), // [RULE9]
    .rdAddr({dataAddrTwo[10:0], dataAddrOne[10:0]}),
    .rdData({dataOutTwo, dataOutOne})
  );

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  assign s_axi_awready = !awTaken && !s_axi_bvalid;
  assign s_axi_wready = !wTaken && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      awTaken <= 1'b0;
      wTaken <= 1'b0;
      awAddrHeld <= 8'h00;
      wDataHeld <= 32'h00000000;
      wStrbHeld <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BMM_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `BMM_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awTaken <= 1'b1;
        awAddrHeld <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wTaken <= 1'b1;
        wDataHeld <= s_axi_wdata;
        wStrbHeld <= s_axi_wstrb;
      end
      if (commit)
      begin
        awTaken <= 1'b0;
        wTaken <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Status and count are read-only; writing them is harmless but flagged
        s_axi_bresp <= (awAddrHeld == `BMM_REG_MODE) ? `BMM_RESP_OKAY : `BMM_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `BMM_RESP_OKAY;
        case (s_axi_araddr)
          `BMM_REG_MODE: s_axi_rdata <= {29'h0, modeThird, mode};
          `BMM_REG_STATUS: s_axi_rdata <= {26'h0, started, (ROM_VARIANT != 0),
                                           loadSrc, loadDone, loading};
          `BMM_REG_COUNT: s_axi_rdata <= {20'h0, wordCount};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `BMM_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // bmm_boot_loader

// *** verification/bmm_boot_loader_checker.sv ***
`timescale 1ns/1ps

module bmm_boot_loader_checker (
  input wire core_clk,
  input wire rst_b,
  input wire modePinLow,
  input wire interruptRequestA,
  input wire [15:0] extAddr,
  input wire extReadEn,
  input wire extAck,
  input wire hostWordReady,
  input wire serialByteReady,
  input wire serialWordLen8,
  input wire serialExtClock,
  input wire serialAsync,
  input wire [15:0] progAddr,
  input wire progFetch,
  input wire [15:0] progReadData,
  input wire progSelBootRom,
  input wire progSelInternal,
  input wire progSelExternal,
  input wire progVectorArea,
  input wire [15:0] resetVector,
  input wire branchToZero,
  input wire [15:0] dataAddrOne,
  input wire [15:0] dataAddrTwo,
  input wire [1:0] dataRegionOne,
  input wire [1:0] dataRegionTwo
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  finish_pulse_a: assert property (branchToZero |=> !branchToZero)
    else $error("finish pulse too long");
  boot_vector_a: assert property (progSelBootRom |-> resetVector == 16'h0000)
    else $error("reset vector wrong while loading");
  boot_fetch_a: assert property (progSelBootRom |-> !progSelInternal && !progSelExternal)
    else $error("fetch leaves loader rom");
  write_only_a: assert property (progFetch && progSelBootRom |=> progReadData == 16'h0000)
    else $error("program ram readable while loading");
  vector_area_a: assert property (progVectorArea == (progAddr <= 16'h003f))
    else $error("vector area decode wrong");
  dram_region_a: assert property (dataAddrOne <= 16'h07ff |-> dataRegionOne == 2'h0)
    else $error("internal data decode wrong");
  periph_region_a: assert property (dataAddrTwo >= 16'hffc0 |-> dataRegionTwo == 2'h2)
    else $error("peripheral decode wrong");
  ext_region_a: assert property (dataAddrOne > 16'h07ff && dataAddrOne < 16'hffc0
    |-> dataRegionOne == 2'h1) else $error("external data decode wrong");
  byte_step_a: assert property (extReadEn && extAck
    |=> !extReadEn || extAddr == $past(extAddr) + 16'h0001) else $error("byte address skipped");
  ext_window_a: assert property (extReadEn |-> extAddr[15:12] == 4'hc)
    else $error("external read outside load window");
  serial_setup_a: assert property (serialByteReady
    |-> serialWordLen8 && serialExtClock && serialAsync) else $error("serial port not set up");
  one_source_a: assert property (hostWordReady |-> !serialByteReady)
    else $error("two load sources open");
  irq_pin_a: assert property (interruptRequestA |-> modePinLow)
    else $error("interrupt request without pin");
endmodule // bmm_boot_loader_checker

bind bmm_boot_loader bmm_boot_loader_checker chk (.*);

// *** verification/bmm_ext_mem_model.sv ***
`timescale 1ns/1ps

module bmm_ext_mem_model (
  input wire core_clk,
  input wire [15:0] extAddr,
  input wire extReadEn,
  input wire pickSerial,
  output logic [15:0] extDataIn,
  output logic extAck
);
  logic held;

  initial
  begin
    extDataIn = 16'h0000;
    extAck = 1'h0;
    held = 1'h0;
  end

  // Odd word pairs answer a cycle late; idle data toggles so stale bytes never match
  always @(posedge core_clk)
  begin
    extAck <= 1'h0;
    extDataIn <= ~extDataIn;
    if (extReadEn && !extAck)
    begin
      if (extAddr[1] && !held)
        held <= 1'h1;
      else
      begin
        held <= 1'h0;
        extAck <= 1'h1;
        extDataIn <= {pickSerial, 7'h00, extAddr[7:0] ^ 8'h5a};
      end
    end
  end
endmodule // bmm_ext_mem_model

// *** verification/bmm_boot_loader_tb_top.sv ***
`timescale 1ns/1ps

module bmm_boot_loader_tb_top;
  logic core_clk = 1'h0, rst_b = 1'h0, modePinLow = 1'h0, modePinHigh = 1'h0;
  logic modePinThird = 1'h0, pickSerial = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, serialByte = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic hostWordValid = 1'h0, hostFlagZero = 1'h0, serialByteValid = 1'h1, progFetch = 1'h0;
  logic progWriteEn = 1'h0, dataReadOne = 1'h0, dataReadTwo = 1'h0, dataWrite = 1'h0;
  logic [15:0] hostWord = 16'h1000, progAddr = 16'h0, progWriteData = 16'h0;
  logic [15:0] dataAddrOne = 16'h0, dataAddrTwo = 16'h0, dataWriteData = 16'h0, k;
  wire interruptRequestA, interruptRequestB, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid, extReadEn, extAck, hostWordReady, serialByteReady;
  wire serialWordLen8, serialExtClock, serialAsync, progSelBootRom, progSelInternal;
  wire progSelExternal, progVectorArea, branchToZero;
  wire [1:0] s_axi_bresp, s_axi_rresp, dataRegionOne, dataRegionTwo;
  wire [31:0] s_axi_rdata;
  wire [15:0] extAddr, extDataIn, progReadData, resetVector, dataOutOne, dataOutTwo;
  int miscompares = 0, samplesChecked = 0, hostTaken = 0;

  bmm_boot_loader uut (.*);
  bmm_ext_mem_model farMem (.*);

  initial
    forever #50 core_clk = ~core_clk;

  initial
  begin
    #6_000_000;
    miscompares++;
    endOfTest;
  end

  // ----------------------------------------
  // Far side sources and bus tasks
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    if (hostWordValid && hostWordReady)
    begin
      hostWord <= hostWord + 16'h0001;
      hostTaken <= hostTaken + 1;
    end
    if (serialByteValid && serialByteReady)
      serialByte <= serialByte + 8'h01;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task endOfTest;
    $display("checks %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task doReset(input logic hi, input logic lo, input logic th);
    @(posedge core_clk);
    rst_b <= 1'h0;
    modePinHigh <= hi;
    modePinLow <= lo;
    modePinThird <= th;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'h1;
    @(posedge core_clk);
  endtask

  task regWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'h1;
    w = 1'h1;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (aw || w)
    begin
      @(negedge core_clk);
      if (s_axi_awready === 1'h1) aw = 1'h0;
      if (s_axi_wready === 1'h1) w = 1'h0;
      @(posedge core_clk);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(negedge core_clk); while (s_axi_bvalid !== 1'h1);
    check(s_axi_bresp, er);
    @(posedge core_clk);
    s_axi_bready <= 1'h0;
  endtask

  task regRd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(negedge core_clk); while (s_axi_arready !== 1'h1);
    @(posedge core_clk);
    s_axi_arvalid <= 1'h0;
    do @(negedge core_clk); while (s_axi_rvalid !== 1'h1);
    check(s_axi_rdata, e);
    check(s_axi_rresp, er);
    @(posedge core_clk);
    s_axi_rready <= 1'h0;
  endtask

  task progRd(input logic [15:0] a, input logic [15:0] e);
    @(posedge core_clk);
    progAddr <= a;
    progFetch <= 1'h1;
    @(posedge core_clk);
    progFetch <= 1'h0;
    @(negedge core_clk);
    check(progReadData, e);
    @(posedge core_clk);
  endtask

  task waitDone;
    do @(negedge core_clk); while (branchToZero !== 1'h1);
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    doReset(1'h0, 1'h0, 1'h0);
    @(negedge core_clk);
    check(progSelBootRom, 1'h1);
    check(resetVector, 16'h0000);
    regRd(8'h04, 32'h21, 2'h0);
    regRd(8'h00, 32'h0, 2'h0);
    progRd(16'h0000, 16'h0000);
    waitDone;
    regRd(8'h08, 32'h800, 2'h0);
    regRd(8'h04, 32'h22, 2'h0);
    regRd(8'h00, 32'h2, 2'h0);
    check(resetVector, 16'he000);
    progRd(16'h0000, 16'h5b5a);
    progRd(16'h07ff, 16'ha5a4);
    progAddr <= 16'h003f;
    dataAddrOne <= 16'h07ff;
    dataAddrTwo <= 16'hffc0;
    @(negedge core_clk);
    check(progVectorArea, 1'h1);
    check(dataRegionOne, 2'h0);
    check(dataRegionTwo, 2'h2);
    progAddr <= 16'h0040;
    dataAddrOne <= 16'h0800;
    dataAddrTwo <= 16'hffbf;
    @(negedge core_clk);
    check(progVectorArea, 1'h0);
    check(dataRegionOne, 2'h1);
    check(dataRegionTwo, 2'h1);
    for (k = 16'h0; k < 16'h2; k++)
    begin
      @(posedge core_clk);
      dataAddrOne <= 16'h0010 + k;
      dataWriteData <= 16'hbe00 + k;
      dataWrite <= 1'h1;
    end
    @(posedge core_clk);
    dataWrite <= 1'h0;
    dataReadOne <= 1'h1;
    dataReadTwo <= 1'h1;
    dataAddrOne <= 16'h0011;
    dataAddrTwo <= 16'h0010;
    @(posedge core_clk);
    dataReadOne <= 1'h0;
    dataReadTwo <= 1'h0;
    @(negedge core_clk);
    check(dataOutOne, 16'hbe01);
    check(dataOutTwo, 16'hbe00);
    regWr(8'h00, 32'h3, 2'h0);
    progAddr <= 16'h0000;
    regRd(8'h00, 32'h3, 2'h0);
    check({progSelExternal, progSelInternal}, 2'h2);
    check(resetVector, 16'h0000);
    regWr(8'h00, 32'h2, 2'h0);
    @(posedge core_clk);
    @(negedge core_clk);
    check({progSelExternal, progSelInternal}, 2'h1);
    regWr(8'h0c, 32'h1, 2'h2);
    regWr(8'h04, 32'h1, 2'h2);
    regRd(8'h0c, 32'h0, 2'h2);
    regWr(8'h00, 32'h1, 2'h0);
    hostWordValid <= 1'h1;
    progWriteEn <= 1'h1;
    progAddr <= 16'h0400;
    progWriteData <= 16'hc0de;
    @(posedge core_clk);
    progWriteEn <= 1'h0;
    do @(negedge core_clk); while (hostTaken != 2);
    @(posedge core_clk);
    hostWordValid <= 1'h0;
    hostFlagZero <= 1'h1;
    waitDone;
    @(posedge core_clk);
    hostFlagZero <= 1'h0;
    regRd(8'h08, 32'h3, 2'h0);
    regRd(8'h04, 32'h26, 2'h0);
    progRd(16'h0002, 16'h1002);
    progRd(16'h0003, 16'h5d5c);
    progRd(16'h0400, 16'hc0de);
    pickSerial <= 1'h1;
    regWr(8'h00, 32'h1, 2'h0);
    waitDone;
    check({serialWordLen8, serialExtClock, serialAsync}, 3'h7);
    regRd(8'h04, 32'h2a, 2'h0);
    progRd(16'h0001, 16'h0302);
    progRd(16'h07ff, 16'hfffe);
    doReset(1'h1, 1'h0, 1'h1);
    regRd(8'h00, 32'h6, 2'h0);
    modePinLow <= 1'h1;
    @(negedge core_clk);
    check(interruptRequestA, 1'h1);
    check(interruptRequestB, 1'h1);
    check(resetVector, 16'he000);
    regRd(8'h00, 32'h6, 2'h0);
    endOfTest;
  end
endmodule // bmm_boot_loader_tb_top
